// *** verilog/encoder_pkg.sv ***
// Purpose: Shared constants for the encoder channel capture block
// Assumes: 250 MHz system clock, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses; every register is one word

package encoder_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = (1000 / CLK_PERIOD_NS) * 1000000;
  localparam int SAMPLE_BASE_MHZ = 100; // Sample rate at divider 0
  localparam int SAMPLE_BASE_HZ = SAMPLE_BASE_MHZ * 1000000;
  localparam int QUAD_MAX_MHZ = 10;     // Highest quadrature rate

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int ADC_W = 16;
  localparam int PHASE_W = 12;
  localparam int POS_W = 32;
  localparam int ANGLE_W = 16;
  localparam int CORDIC_ITER = 14;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ENC_DIV = 8'h04;
  localparam logic [7:0] OFS_ADC_DIV = 8'h08;
  localparam logic [7:0] OFS_ADC_CTRL = 8'h0c;
  localparam logic [7:0] OFS_ADC_DELAY = 8'h10;
  localparam logic [7:0] OFS_HEADER = 8'h14;
  localparam logic [7:0] OFS_STROBE = 8'h18;
  localparam logic [7:0] OFS_UTOS = 8'h1c;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  localparam logic [7:0] OFS_LATCHED = 8'h24;
  localparam logic [7:0] OFS_PHASE = 8'h28;
  localparam logic [7:0] OFS_POSITION = 8'h2c;

  // Flag register bit positions
  localparam int FLAG_B_BIT = 0;
  localparam int FLAG_C_BIT = 1;
  localparam int FLAG_D_BIT = 2;
  localparam int SER_ENA_BIT = 3;
  localparam int SIN_MODE_BIT = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] RST_ENC_DIV = 4'h3;
  localparam logic [3:0] RST_ADC_DIV = 4'h3;
  localparam logic [31:0] RST_ADC_CTRL = 32'h3fffc000;
  localparam logic [7:0] RST_ADC_DELAY = 8'h00;
  localparam logic [7:0] RST_HEADER = 8'h00;
  localparam logic [23:0] RST_STROBE = 24'h3fffc0;
  localparam logic RST_UTOS = 1'b0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Angle of half a turn in the arctangent accumulator
  localparam logic [15:0] HALF_TURN = 16'h8000;

  // Capture sequence; only idle to wait and wait to merge change a single bit
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_MERGE = 2'b11
  } cap_state_t;

endpackage : encoder_pkg

// *** verilog/atan_cordic.sv ***
// Purpose: Sequential arctangent of a sine and cosine pair
// Assumes: Inputs are signed; result is a fraction of one turn
// Notes:   One iteration per clock; done pulses for one cycle

`timescale 1ns/1ps

module atan_cordic
  import encoder_pkg::*;
#(
  parameter int W = ADC_W,
  parameter int PW = PHASE_W,
  parameter int ITER = CORDIC_ITER
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic signed [W-1:0] x_in,
  input wire logic signed [W-1:0] y_in,
  output logic [PW-1:0] phase,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [4:0] step;
    logic [W+1:0] x;
    logic [W+1:0] y;
    logic [ANGLE_W-1:0] z;
    logic [PW-1:0] phase;
    logic done;
  } cordic_t;

  cordic_t s;
  cordic_t next_s;

  // Angle of atan(2^-i) in units of 1/65536 turn
  function automatic logic [15:0] atan_step(input logic [4:0] i);
    case (i)
      5'd0: atan_step = 16'h2000;
      5'd1: atan_step = 16'h12e4;
      5'd2: atan_step = 16'h09fb;
      5'd3: atan_step = 16'h0511;
      5'd4: atan_step = 16'h028b;
      5'd5: atan_step = 16'h0146;
      5'd6: atan_step = 16'h00a3;
      5'd7: atan_step = 16'h0051;
      5'd8: atan_step = 16'h0029;
      5'd9: atan_step = 16'h0014;
      5'd10: atan_step = 16'h000a;
      5'd11: atan_step = 16'h0005;
      5'd12: atan_step = 16'h0003;
      5'd13: atan_step = 16'h0001;
      default: atan_step = 16'h0000;
    endcase
  endfunction : atan_step

  // ****************************************************************
  // Vectoring iterations
  // ****************************************************************
  always_comb begin
    logic signed [W+1:0] xs;
    logic signed [W+1:0] ys;
    logic signed [W+1:0] xe;
    logic signed [W+1:0] ye;
    xs = '0;
    ys = '0;
    xe = '0;
    ye = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (start) begin
      // Fold left half plane onto the right
      xe = (W+2)'(x_in);
      ye = (W+2)'(y_in);
      next_s.busy = 1'b1;
      next_s.step = '0;
      if (x_in < 0) begin
        next_s.x = -xe;
        next_s.y = -ye;
        next_s.z = HALF_TURN;
      end else begin
        next_s.x = xe;
        next_s.y = ye;
        next_s.z = '0;
      end
    end else if (s.busy) begin
      xs = $signed(s.x) >>> s.step;
      ys = $signed(s.y) >>> s.step;
      if ($signed(s.y) >= 0) begin
        next_s.x = s.x + ys;
        next_s.y = s.y - xs;
        next_s.z = s.z + atan_step(s.step);
      end else begin
        next_s.x = s.x - ys;
        next_s.y = s.y + xs;
        next_s.z = s.z - atan_step(s.step);
      end
      if (s.step == 5'(ITER - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.phase = next_s.z[ANGLE_W-1 -: PW];
      end else begin
        next_s.step = s.step + 5'd1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase = s.phase;
  assign done = s.done;

endmodule : atan_cordic

// *** verilog/encoder_channel.sv ***
// Purpose: Encoder channel capture, position merge and output flags
// Assumes: Encoder and servo clock pins are asynchronous to clk
// Notes:   Registers reached over AXI4-Lite, one word per register

`timescale 1ns/1ps

// Function
// - Count every edge of phase A or phase B alone, times four; a change of both at once is not counted.
// - Latch the edge count once per servo clock period.
// - Sample sine and cosine on servo clock, take their arctangent.
// - Merge latched coarse count and fine phase into one position.
// - Dividers reset to 3; delay, header bits, signed conversion to 0.
// - Converter control and strobe words reset to fixed patterns.
// - Divider 0 samples encoder at 100 MHz, up to 10 MHz input.
// - Flag B zero turns transistor off, one turns it on.
// - Flag C picks serial clock at zero, servo clock at one.
// - Termination on only when flag D is 0 and serial enable 1.
module encoder_channel
  import encoder_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic servo_clock_pin,
  input wire logic serial_encoder_clock,
  input wire logic [ADC_W-1:0] sine_result,
  input wire logic [ADC_W-1:0] cosine_result,
  output logic transistor_output,
  output logic clock_out_p,
  output logic clock_out_n,
  output logic data_termination_enable,
  output logic [POS_W-1:0] position,
  output logic position_valid
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Software settings
    logic transistor_output_flag;
    logic clock_output_select;
    logic data_termination_disable;
    logic serial_encoder_enable;
    logic sin_mode;
    logic [3:0] encoder_sample_clock_divider;
    logic [3:0] converter_clock_divider;
    logic [31:0] converter_control_word;
    logic [7:0] converter_delay;
    logic [7:0] converter_header_bit_count;
    logic [23:0] converter_strobe_pattern;
    logic converter_unsigned_to_signed;
    // Pin synchronisers and sampled phases
    logic a_meta;
    logic a_sync;
    logic b_meta;
    logic b_sync;
    logic servo_meta;
    logic servo_sync;
    logic servo_prev;
    logic a_smp;
    logic b_smp;
    logic a_old;
    logic b_old;
    logic [31:0] rate_acc;
    // Position path
    logic [31:0] count;
    logic [31:0] latched;
    logic [ADC_W-1:0] sin_cap;
    logic [ADC_W-1:0] cos_cap;
    logic cordic_start;
    cap_state_t cap;
    logic [PHASE_W-1:0] phase;
    logic [POS_W-1:0] position;
    logic position_valid;
    // Outputs toward the connector
    logic transistor_output;
    logic clock_out_p;
    logic clock_out_n;
    logic term_en;
    // Register bus
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } chan_t;

  chan_t s;
  chan_t next_s;
  logic [PHASE_W-1:0] cordic_phase;
  logic cordic_done;

  // ****************************************************************
  // Arctangent unit
  // ****************************************************************
  atan_cordic #(
    .W(ADC_W),
    .PW(PHASE_W),
    .ITER(CORDIC_ITER)
  ) u_atan (
    .clk(clk),
    .srst(srst),
    .start(s.cordic_start),
    .x_in(s.cos_cap),
    .y_in(s.sin_cap),
    .phase(cordic_phase),
    .done(cordic_done)
  );

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Whether an address names a register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_POSITION);
  endfunction : mapped

  // Read value of a register
  function automatic logic [31:0] rd(input chan_t c,
                                     input logic [ADDR_W-1:0] a);
    case (a)
      OFS_FLAGS: rd = {27'h0, c.sin_mode, c.serial_encoder_enable,
                       c.data_termination_disable,
                       c.clock_output_select,
                       c.transistor_output_flag};
      OFS_ENC_DIV: rd = {28'h0, c.encoder_sample_clock_divider};
      OFS_ADC_DIV: rd = {28'h0, c.converter_clock_divider};
      OFS_ADC_CTRL: rd = c.converter_control_word;
      OFS_ADC_DELAY: rd = {24'h0, c.converter_delay};
      OFS_HEADER: rd = {24'h0, c.converter_header_bit_count};
      OFS_STROBE: rd = {8'h0, c.converter_strobe_pattern};
      OFS_UTOS: rd = {31'h0, c.converter_unsigned_to_signed};
      OFS_COUNT: rd = c.count;
      OFS_LATCHED: rd = c.latched;
      OFS_PHASE: rd = {{(32 - PHASE_W){1'b0}}, c.phase};
      OFS_POSITION: rd = c.position;
      default: rd = 32'h0;
    endcase
  endfunction : rd

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] step;
    logic [31:0] acc;
    logic tick;
    logic a_chg;
    logic b_chg;
    logic [31:0] wv;
    logic [31:0] rv;
    step = '0;
    acc = '0;
    tick = 1'b0;
    a_chg = 1'b0;
    b_chg = 1'b0;
    wv = '0;
    rv = '0;
    next_s = s;
    next_s.cordic_start = 1'b0;
    next_s.position_valid = 1'b0;

    // Two-flop pin synchronisers
    next_s.a_meta = phase_a_pin;
    next_s.a_sync = s.a_meta;
    next_s.b_meta = phase_b_pin;
    next_s.b_sync = s.b_meta;
    next_s.servo_meta = servo_clock_pin;
    next_s.servo_sync = s.servo_meta;
    next_s.servo_prev = s.servo_sync;

    // Encoder sample clock as a rate accumulator
    step = SAMPLE_BASE_HZ >> s.encoder_sample_clock_divider;
    acc = s.rate_acc + step;
    if (acc >= 32'(CLK_HZ)) begin
      tick = 1'b1;
      acc = acc - 32'(CLK_HZ);
    end
    next_s.rate_acc = acc;

    // Second sampling stage on the sample clock
    if (tick) begin
      next_s.a_smp = s.a_sync;
      next_s.b_smp = s.b_sync;
      next_s.a_old = s.a_smp;
      next_s.b_old = s.b_smp;
    end

    // Times-four edge count with direction
    a_chg = s.a_smp ^ s.a_old;
    b_chg = s.b_smp ^ s.b_old;
    if (tick && (a_chg ^ b_chg)) begin
      if (s.a_smp ^ s.b_old) begin
        next_s.count = s.count + 32'd1;
      end else begin
        next_s.count = s.count - 32'd1;
      end
    end

    // Servo clock rising edge starts a capture
    case (s.cap)
      CAP_IDLE: begin
        if (s.servo_sync && !s.servo_prev) begin
          next_s.latched = next_s.count;
          next_s.sin_cap = sine_result;
          next_s.cos_cap = cosine_result;
          if (s.converter_unsigned_to_signed) begin
            next_s.sin_cap[ADC_W-1] = ~sine_result[ADC_W-1];
            next_s.cos_cap[ADC_W-1] = ~cosine_result[ADC_W-1];
          end
          if (s.sin_mode) begin
            next_s.cordic_start = 1'b1;
            next_s.cap = CAP_WAIT;
          end else begin
            next_s.phase = '0;
            next_s.cap = CAP_MERGE;
          end
        end
      end
      CAP_WAIT: begin
        if (cordic_done) begin
          next_s.phase = cordic_phase;
          next_s.cap = CAP_MERGE;
        end
      end
      CAP_MERGE: begin
        // Coarse count above the fine phase of one period
        if (s.sin_mode) begin
          next_s.position = {s.latched[POS_W-PHASE_W+1:2],
                             s.phase};
        end else begin
          next_s.position = {s.latched[POS_W-PHASE_W-1:0],
                             {PHASE_W{1'b0}}};
        end
        next_s.position_valid = 1'b1;
        next_s.cap = CAP_IDLE;
      end
      default: begin
        next_s.cap = CAP_IDLE;
      end
    endcase

    // Connector outputs
    next_s.transistor_output = s.transistor_output_flag;
    if (s.clock_output_select) begin
      next_s.clock_out_p = s.servo_sync;
    end else begin
      next_s.clock_out_p = serial_encoder_clock;
    end
    next_s.clock_out_n = ~next_s.clock_out_p;
    next_s.term_en = !s.data_termination_disable &&
                     s.serial_encoder_enable;

    // Write address and data, taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
      next_s.awready = 1'b0;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
      next_s.wready = 1'b0;
    end

    // Perform the write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      wv = merge(rd(s, s.aw_addr), s.w_data, s.w_strb);
      case (s.aw_addr)
        OFS_FLAGS: begin
          next_s.transistor_output_flag = wv[FLAG_B_BIT];
          next_s.clock_output_select = wv[FLAG_C_BIT];
          next_s.data_termination_disable = wv[FLAG_D_BIT];
          next_s.serial_encoder_enable = wv[SER_ENA_BIT];
          next_s.sin_mode = wv[SIN_MODE_BIT];
        end
        OFS_ENC_DIV: next_s.encoder_sample_clock_divider = wv[3:0];
        OFS_ADC_DIV: next_s.converter_clock_divider = wv[3:0];
        OFS_ADC_CTRL: next_s.converter_control_word = wv;
        OFS_ADC_DELAY: next_s.converter_delay = wv[7:0];
        OFS_HEADER: next_s.converter_header_bit_count = wv[7:0];
        OFS_STROBE: next_s.converter_strobe_pattern = wv[23:0];
        OFS_UTOS: next_s.converter_unsigned_to_signed = wv[0];
        default: begin
          next_s.bvalid = 1'b1;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // Read: answer the cycle after the address is taken
    if (s.arready && s_axi_arvalid) begin
      rv = rd(s, s_axi_araddr);
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rv;
      next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // ****************************************************************
  // State register with reset defaults
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.encoder_sample_clock_divider <= RST_ENC_DIV;
      s.converter_clock_divider <= RST_ADC_DIV;
      s.converter_delay <= RST_ADC_DELAY;
      s.converter_header_bit_count <= RST_HEADER;
      s.converter_unsigned_to_signed <= RST_UTOS;
      s.converter_control_word <= RST_ADC_CTRL;
      s.converter_strobe_pattern <= RST_STROBE;
      s.cap <= CAP_IDLE;
      s.clock_out_n <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign transistor_output = s.transistor_output;
  assign clock_out_p = s.clock_out_p;
  assign clock_out_n = s.clock_out_n;
  assign data_termination_enable = s.term_en;
  assign position = s.position;
  assign position_valid = s.position_valid;

endmodule : encoder_channel

// *** testbench/encoder_channel_asserts.sv ***
// Purpose: Port checks for the encoder channel block
// Assumes: One clock domain, srst synchronous active high
// Notes:   Bound into encoder_channel
`timescale 1ns/1ps
module encoder_channel_asserts
  import encoder_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic servo_clock_pin,
  input wire logic transistor_output,
  input wire logic clock_out_p,
  input wire logic clock_out_n,
  input wire logic data_termination_enable,
  input wire logic position_valid
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] wa;
  logic [3:0] wf;
  logic [7:0] ra;
  // Remember the last taken addresses and flag bits
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wf <= s_axi_wdata[3:0];
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  function automatic logic bad_a(logic [7:0] a);
    return a > 8'h2c || a[1:0] != 2'b00;
  endfunction : bad_a
  sequence both_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_pair_inverse: assert property (clock_out_n == !clock_out_p)
    else $error("clock pair not complementary");
  a_reset_vals: assert property ($fell(srst) |-> !transistor_output
    && !data_termination_enable && !clock_out_p && !position_valid)
    else $error("outputs wrong after reset");
  a_write_ans: assert property (both_take |-> b_answer)
    else $error("write not answered");
  a_read_ans: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_arready ##[0:1] s_axi_rvalid)
    else $error("read not answered");
  a_bresp_code: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (bad_a(wa) ? RESP_SLVERR : RESP_OKAY))
    else $error("write response code wrong");
  a_rresp_code: assert property ($rose(s_axi_rvalid) |->
    s_axi_rresp == (bad_a(ra) ? RESP_SLVERR : RESP_OKAY)
    && (!bad_a(ra) || s_axi_rdata == 32'h0))
    else $error("read response wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_flag_out: assert property ($rose(s_axi_bvalid) && wa == OFS_FLAGS
    |-> ##2 transistor_output == wf[0]
    && data_termination_enable == (!wf[2] && wf[3]))
    else $error("flag outputs wrong");
  a_valid_pulse: assert property (position_valid |=> !position_valid)
    else $error("position valid too long");
  a_capture_due: assert property ($rose(servo_clock_pin)
    |-> ##[1:40] position_valid)
    else $error("no capture after servo edge");
endmodule : encoder_channel_asserts

bind encoder_channel encoder_channel_asserts u_chk (.*);

// *** testbench/encoder_model.sv ***
// Purpose: Quadrature and sinusoidal encoder seen by the channel
// Assumes: move 01 steps up, 10 down, 11 flips both phases
// Notes:   Sine and cosine sit at one of four quarter turns
`timescale 1ns/1ps
module encoder_model
  import encoder_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] move,
  input wire logic [1:0] quad,
  output logic phase_a,
  output logic phase_b,
  output logic [ADC_W-1:0] sine,
  output logic [ADC_W-1:0] cosine
);
  localparam logic [15:0] AMP = 16'h3000;
  logic [1:0] idx = 2'h0;
  // Step through 00,10,11,01 on {a,b}
  always @(posedge clk) begin
    if (move == 2'b01) idx <= idx + 2'h1;
    if (move == 2'b10) idx <= idx - 2'h1;
    if (move == 2'b11) idx <= idx + 2'h2;
  end
  assign phase_a = idx[1] ^ idx[0];
  assign phase_b = idx[1];
  // Cosine leads sine by a quarter turn
  assign sine = quad[0] ? (quad[1] ? -AMP : AMP) : 16'h0;
  assign cosine = quad[0] ? 16'h0 : (quad[1] ? -AMP : AMP);
endmodule : encoder_model

// *** testbench/encoder_channel_capture_and_flags_bench.sv ***
// Purpose: Self-checking bench for the encoder channel
// Assumes: 250 MHz clock, seed 47
// Notes:   Registers reached over AXI4-Lite tasks
`timescale 1ns/1ps
module encoder_channel_capture_and_flags_bench
  import encoder_pkg::*;
;
  logic clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, position, exp;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, move, quad;
  logic phase_a_pin, phase_b_pin, servo_clock_pin, serial_encoder_clock;
  logic [15:0] sine_result, cosine_result;
  logic transistor_output, clock_out_p, clock_out_n;
  logic data_termination_enable, position_valid, sv, sc;
  logic [11:0] ph;
  int bad_count, n_tests, cycles;
  logic [31:0] rvl [8] = '{32'h0, 32'h3, 32'h3, 32'h3fffc000, 32'h0,
    32'h0, 32'h3fffc0, 32'h0};
  encoder_channel u_dut (.*);
  encoder_model u_enc (.clk, .move, .quad, .phase_a(phase_a_pin),
    .phase_b(phase_b_pin), .sine(sine_result), .cosine(cosine_result));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // Quadrature position: latched count above an empty fine field
  function automatic logic [31:0] quad_pos(input logic [31:0] c);
    return {c[19:0], 12'h0};
  endfunction : quad_pos
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit ad;
    bit dd;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    ad = 0;
    dd = 0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] want,
    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, want);
    check(32'(s_axi_rresp), 32'(er));
  endtask : rchk
  task automatic capture();
    servo_clock_pin <= 1'b0;
    repeat (40) @(posedge clk);
    servo_clock_pin <= 1'b1;
    do @(posedge clk); while (position_valid !== 1'b1);
  endtask : capture
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // ****************************************************************
  // Clock, timeout and tests
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, servo_clock_pin, serial_encoder_clock} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, move, quad} = 52'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(47));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rchk(8'(4 * i), rvl[i], RESP_OKAY);
    end
    $display("reset values done");
    for (int f = 0; f < 16; f++) begin
      {sv, sc} = 2'($urandom);
      {servo_clock_pin, serial_encoder_clock} <= {sv, sc};
      wr(OFS_FLAGS, 32'(f), RESP_OKAY);
      repeat (6) @(posedge clk);
      check(32'(transistor_output), 32'(f[0]));
      check(32'(clock_out_p), 32'(f[1] ? sv : sc));
      check(32'(data_termination_enable), 32'(!f[2] && f[3]));
    end
    rchk(OFS_FLAGS, 32'hf, RESP_OKAY);
    $display("output flags done");
    wr(8'h30, 32'h5, RESP_SLVERR);
    rchk(8'h30, 32'h0, RESP_SLVERR);
    rchk(8'h06, 32'h0, RESP_SLVERR);
    wr(OFS_COUNT, 32'h1234, RESP_OKAY);
    $display("bus errors done");
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    wr(OFS_ENC_DIV, 32'h0, RESP_OKAY);
    exp = 32'h0;
    for (int i = 0; i < 200; i++) begin
      move <= 2'($urandom_range(1, 3));
      @(posedge clk);
      if (move == 2'b01) exp++;
      if (move == 2'b10) exp--;
      move <= 2'b00;
      repeat (6) @(posedge clk);
    end
    rchk(OFS_COUNT, exp, RESP_OKAY);
    capture();
    check(position, quad_pos(exp));
    rchk(OFS_LATCHED, exp, RESP_OKAY);
    $display("quadrature count done");
    wr(OFS_FLAGS, 32'h10, RESP_OKAY);
    for (int q = 0; q < 4; q++) begin
      quad <= 2'(q);
      capture();
      ph = position[11:0] - 12'(q * 1024) + 12'h2;
      check(32'(ph < 12'h5), 32'h1);
      check(32'(position[31:12]), 32'(exp[21:2]));
    end
    $display("sinusoidal phase done");
    test_done();
  end
endmodule : encoder_channel_capture_and_flags_bench
